// *** common/cbl_defs.svh ***
// Purpose: Timing counts, pin codes and sizes for the configuration loader
// Assumes: sys_clk at 125 MHz
// Notes: Cycle counts are derived from times in ns; least times round up
`ifndef CBL_DEFS_SVH
`define CBL_DEFS_SVH

// System clock period
`define CBL_CLK_PERIOD_NS 8

// Half period of the configuration clock this end makes in master mode
`define CBL_MCLK_HALF_NS 500
`define CBL_MCLK_HALF_CYC ((`CBL_MCLK_HALF_NS + `CBL_CLK_PERIOD_NS - 1) / `CBL_CLK_PERIOD_NS)

// Time the memory-clear status line is held low after reset
`define CBL_CLEAR_NS 5000
`define CBL_CLEAR_CYC ((`CBL_CLEAR_NS + `CBL_CLK_PERIOD_NS - 1) / `CBL_CLK_PERIOD_NS)

// Mode select pin codes, high pin first
`define CBL_PINS_SERIAL 3'h7
`define CBL_PINS_SYNC 3'h3
`define CBL_PINS_MPAR_DOWN 3'h6
`define CBL_PINS_MPAR_UP 3'h4

// Peripheral byte timing in config clock rising edges
`define CBL_SYNC_FIRST_EDGE 2
`define CBL_BYTE_EDGES 8

// Bits in a byte, and input synchroniser width
`define CBL_BYTE_BITS 4'h8
`define CBL_SYNC_W 14

`endif

// *** common/cbl_pkg.sv ***
// Purpose: Types shared by the configuration loader
// Assumes: Nothing beyond the defs header
// Notes: Codes are written out so waveforms read the same in every tool
package cbl_pkg;

   // Loading mode latched at the end of memory clear
   typedef enum logic [2:0] {
      cbl_mode_none = 3'b000,
      cbl_mode_serial = 3'b001,
      cbl_mode_sync = 3'b010,
      cbl_mode_mpar_up = 3'b011,
      cbl_mode_mpar_down = 3'b100
   } cbl_mode_e;

   // Loader sequence
   typedef enum logic [1:0] {
      cbl_st_clear = 2'b00,
      cbl_st_wait = 2'b01,
      cbl_st_load = 2'b10,
      cbl_st_halt = 2'b11
   } cbl_state_e;

endpackage

// *** rtl/cbl_fifo.sv ***
// Purpose: Buffer between the loader's byte assembler and the config memory writer
// Assumes: Both sides on sys_clk
// Notes: Output word is held in a register, so out_data never comes from the array directly
`timescale 1ns/1ns
`default_nettype none
module cbl_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Filling side
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   // Draining side
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);

   // Pointer wrap relies on a power-of-two depth
   generate
      if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_param
         $error("cbl_fifo: DEPTH must be a power of two of at least 2");
      end
   endgenerate

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic [AW:0] count, next_count;
   logic next_out_valid;
   logic [WIDTH-1:0] next_out_data;
   logic do_wr, do_rd;

   // Next pointers, fill level and output stage
   always_comb begin
      in_ready = (count != (AW+1)'(DEPTH));
      do_wr = in_valid && in_ready;
      do_rd = (count != '0) && (!out_valid || out_ready);
      next_wr_ptr = do_wr ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr = do_rd ? rd_ptr + 1'b1 : rd_ptr;
      next_count = count;
      if (do_wr && !do_rd) begin
         next_count = count + 1'b1;
      end else if (do_rd && !do_wr) begin
         next_count = count - 1'b1;
      end
      next_out_valid = do_rd ? 1'b1 : (out_ready ? 1'b0 : out_valid);
      next_out_data = do_rd ? mem[rd_ptr] : out_data;
   end

   // Registers and array write
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
         out_valid <= 1'b0;
         out_data <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
         out_valid <= next_out_valid;
         out_data <= next_out_data;
      end
      if (do_wr) begin
         mem[wr_ptr] <= in_data;
      end
   end

   // Never written while full, never read while empty
   fifo_bounds_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      count <= (AW+1)'(DEPTH)) else $error("fifo level out of range");
endmodule
`default_nettype wire

// *** rtl/cbl_loader.sv ***
// Purpose: Configuration bitstream loader, slave serial, synchronous peripheral, master parallel
// Assumes: Config clock and all pins are asynchronous to sys_clk and far slower than it
// Notes: Own bits go to the FIFO as bytes, first bit in the byte's MSB
// Operation
// RULE1: Serial bit sampled on config clock rise
// RULE2: Forward preamble and overflow bits down chain
// RULE3: Chain output changes on falling clock edge
// RULE4: Pins all ones select slave serial
// RULE5: Unconnected pins pulled high, slave serial default
// RULE6: Source waits for every status line high
// RULE7: Status line driven open drain only
// RULE8: Master loads byte at rise ending strobe
// RULE9: Peripheral first byte on second rise
// RULE10: Peripheral byte every eighth rise after
// RULE11: Acknowledge high one clock after capture
// RULE12: Shift loaded byte out half period later
// RULE13: ROM address steps once per byte read
// RULE14: Mode sampled once, held until done
`timescale 1ns/1ns
`default_nettype none
`include "cbl_defs.svh"
module cbl_loader #(
   parameter int PREAMBLE_BITS = 40,
   parameter int CONFIG_BITS = 1024,
   parameter int MASTER_BYTES = (PREAMBLE_BITS + CONFIG_BITS + 7) / 8,
   parameter int ADDR_W = 18,
   parameter int FIFO_DEPTH = 16
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Mode select pins
   input wire logic mode_select_hi,
   input wire logic mode_select_mid,
   input wire logic mode_select_lo,
   // Memory-clear status line, open drain
   input wire logic init_in,
   output logic init_out,
   output logic init_oe,
   // Configuration clock pin, two-way
   input wire logic config_clock_in,
   output logic config_clock_out,
   output logic config_clock_oe,
   // Bitstream in and daisy chain out
   input wire logic serial_din,
   input wire logic [7:0] parallel_config_byte,
   output logic chain_dout,
   // ROM side, master parallel
   output logic rom_read_strobe,
   output logic [ADDR_W-1:0] rom_addr,
   // Peripheral acknowledge
   output logic byte_ack,
   // Pull-up control for the mode pins
   output logic mode_pullup_en,
   // Own configuration bytes
   output logic cfg_valid,
   output logic [7:0] cfg_byte,
   input wire logic cfg_ready,
   // Status
   output logic config_done,
   output logic overflow_err
);
   localparam int TOTAL = PREAMBLE_BITS + CONFIG_BITS;
   localparam int CNT_W = $clog2(TOTAL + 2);

   // Parameters the logic cannot serve
   generate
      if (CONFIG_BITS < 8 || CONFIG_BITS % 8 != 0 || PREAMBLE_BITS < 0 || MASTER_BYTES < 1
          || ADDR_W < 1 || ADDR_W > 30 || MASTER_BYTES > (1 << ADDR_W)) begin : g_bad_param
         $error("cbl_loader: parameter values not supported");
      end
   endgenerate

   // True for bit positions kept by this device
   function automatic logic is_own(input logic [CNT_W-1:0] idx);
      is_own = (idx >= CNT_W'(PREAMBLE_BITS)) && (idx < CNT_W'(TOTAL));
   endfunction

   // Pin code to mode; anything unlisted stops loading
   function automatic cbl_pkg::cbl_mode_e decode_mode(input logic [2:0] pins);
      if (pins == `CBL_PINS_SERIAL) begin
         decode_mode = cbl_pkg::cbl_mode_serial;
      end else if (pins == `CBL_PINS_SYNC) begin
         decode_mode = cbl_pkg::cbl_mode_sync;
      end else if (pins == `CBL_PINS_MPAR_UP) begin
         decode_mode = cbl_pkg::cbl_mode_mpar_up;
      end else if (pins == `CBL_PINS_MPAR_DOWN) begin
         decode_mode = cbl_pkg::cbl_mode_mpar_down;
      end else begin
         decode_mode = cbl_pkg::cbl_mode_none;
      end
   endfunction

   // Pin synchronisers: three stages, a change counts once stages two and three agree
   logic [`CBL_SYNC_W-1:0] raw_in, sync1, sync2, sync3, filt, next_filt;
   logic config_clock_prev;
   logic config_clock_lvl, din_lvl, init_lvl, pin_rise, pin_fall;
   logic [2:0] pins;
   logic [7:0] pbyte;
   assign raw_in = {parallel_config_byte, mode_select_hi, mode_select_mid, mode_select_lo,
                    init_in, serial_din, config_clock_in};
   assign config_clock_lvl = filt[0];
   assign din_lvl = filt[1];
   assign init_lvl = filt[2];
   assign pins = filt[5:3];
   assign pbyte = filt[13:6];
   assign pin_rise = config_clock_lvl && !config_clock_prev;
   assign pin_fall = !config_clock_lvl && config_clock_prev;

   // Agreement filter, bitwise: keep old value while stages disagree
   always_comb begin
      next_filt = (sync2 & sync3) | (filt & (sync2 | sync3));
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         sync1 <= '0;
         sync2 <= '0;
         sync3 <= '0;
         filt <= '0;
         config_clock_prev <= 1'b0;
      end else begin
         sync1 <= raw_in;
         sync2 <= sync1;
         sync3 <= sync2;
         filt <= next_filt;
         config_clock_prev <= filt[0];
      end
   end

   // Loader state
   cbl_pkg::cbl_state_e state, next_state;
   cbl_pkg::cbl_mode_e mode, next_mode;
   logic [11:0] clr_cnt, next_clr_cnt;
   logic [7:0] div, next_div;
   logic ph, next_ph, m_started, next_m_started, m_strobe, next_m_strobe;
   logic [ADDR_W:0] bytes_read, next_bytes_read;
   logic [ADDR_W-1:0] next_rom_addr;
   logic [2:0] byte_ph, next_byte_ph, asm_cnt, next_asm_cnt;
   logic [7:0] shreg, next_shreg, asm_byte, next_asm_byte, push_data, next_push_data;
   logic [3:0] sh_left, next_sh_left;
   logic ser_bit, next_ser_bit, ser_pend, next_ser_pend, push, next_push;
   logic [CNT_W-1:0] bit_cnt, next_bit_cnt;
   logic next_init_oe, next_config_clock_out, next_config_clock_oe, next_chain_dout, next_byte_ack;
   logic next_done, next_ovf;
   logic is_master, m_tick, rise, fall, sync_cap, m_load, bit_ev, bit_val, fifo_in_ready;

   // Next values of the whole loader
   always_comb begin
      next_state = state;
      next_mode = mode;
      next_clr_cnt = clr_cnt;
      next_init_oe = init_oe;
      next_div = div;
      next_ph = ph;
      next_m_started = m_started;
      next_m_strobe = m_strobe;
      next_bytes_read = bytes_read;
      next_rom_addr = rom_addr;
      next_byte_ph = byte_ph;
      next_asm_cnt = asm_cnt;
      next_shreg = shreg;
      next_asm_byte = asm_byte;
      next_push_data = push_data;
      next_sh_left = sh_left;
      next_ser_bit = ser_bit;
      next_ser_pend = ser_pend;
      next_push = 1'b0;
      next_bit_cnt = bit_cnt;
      next_config_clock_oe = config_clock_oe;
      next_chain_dout = chain_dout;
      next_byte_ack = byte_ack;
      next_done = config_done;
      next_ovf = overflow_err || (push && !fifo_in_ready);
      is_master = (mode == cbl_pkg::cbl_mode_mpar_up) || (mode == cbl_pkg::cbl_mode_mpar_down);
      m_tick = 1'b0;
      sync_cap = 1'b0;
      m_load = 1'b0;
      bit_ev = 1'b0;
      bit_val = 1'b0;
      // Master end makes its own clock from sys_clk, so it is no second domain
      if (state == cbl_pkg::cbl_st_load && is_master) begin
         if (div == 8'(`CBL_MCLK_HALF_CYC - 1)) begin
            next_div = '0;
            m_tick = 1'b1;
         end else begin
            next_div = div + 8'h01;
         end
      end
      if (m_tick) begin
         next_ph = !ph;
      end
      rise = (state == cbl_pkg::cbl_st_load) && (is_master ? (m_tick && !ph) : pin_rise);
      fall = (state == cbl_pkg::cbl_st_load) && (is_master ? (m_tick && ph) : pin_fall);
      case (state)
         cbl_pkg::cbl_st_clear: begin
            next_init_oe = 1'b1;
            if (clr_cnt == 12'(`CBL_CLEAR_CYC - 1)) begin
               next_mode = decode_mode(pins);                  // Sampled once here only [RULE14] [RULE4]
               next_init_oe = (next_mode == cbl_pkg::cbl_mode_none);
               next_config_clock_oe = (next_mode == cbl_pkg::cbl_mode_mpar_up)
                              || (next_mode == cbl_pkg::cbl_mode_mpar_down);
               next_rom_addr = (next_mode == cbl_pkg::cbl_mode_mpar_down) ? '1 : '0;
               next_state = (next_mode == cbl_pkg::cbl_mode_none) ? cbl_pkg::cbl_st_halt
                                                                  : cbl_pkg::cbl_st_wait;
            end else begin
               next_clr_cnt = clr_cnt + 12'h001;
            end
         end
         cbl_pkg::cbl_st_wait: begin
            // Nothing is taken until the shared line is high everywhere [RULE6]
            if (init_lvl) begin
               next_state = cbl_pkg::cbl_st_load;
            end
         end
         cbl_pkg::cbl_st_load: begin
            if (is_master && m_started && sh_left == 4'h0 && !m_strobe
                && bytes_read == (ADDR_W+1)'(MASTER_BYTES)) begin
               next_state = cbl_pkg::cbl_st_halt;
            end
         end
         default: begin
         end
      endcase
      // Slave serial: bit taken on the rise, passed on at the fall
      if (mode == cbl_pkg::cbl_mode_serial && rise) begin
         next_ser_bit = din_lvl;                                  // [RULE1]
         next_ser_pend = 1'b1;
      end
      // Peripheral: byte phase counter, second rise first, then every eighth
      if (mode == cbl_pkg::cbl_mode_sync && rise) begin
         if (byte_ph == 3'(`CBL_BYTE_EDGES - 1)) begin
            sync_cap = 1'b1;                                      // [RULE9] [RULE10]
            next_byte_ph = 3'h0;
         end else begin
            next_byte_ph = byte_ph + 3'h1;
         end
         next_byte_ack = sync_cap;                                // One full clock period [RULE11]
      end
      // Master: the rise that ends the strobe cycle loads the byte and starts the clock
      if (is_master && rise && m_strobe) begin
         m_load = 1'b1;                                           // [RULE8]
         next_m_strobe = 1'b0;
         next_m_started = 1'b1;
         next_bytes_read = bytes_read + 1'b1;
         next_rom_addr = (mode == cbl_pkg::cbl_mode_mpar_up) ? rom_addr + 1'b1
                                                             : rom_addr - 1'b1; // [RULE13]
      end
      // A read starts only with room for its byte, so the FIFO stalls the ROM side
      if (is_master && fall && !m_strobe && sh_left == 4'h0 && !push && fifo_in_ready
          && bytes_read != (ADDR_W+1)'(MASTER_BYTES)) begin
         next_m_strobe = 1'b1;
      end
      if (sync_cap || m_load) begin
         next_shreg = pbyte;
         next_sh_left = `CBL_BYTE_BITS;
      end
      // Bits leave on the fall, half a period after the rise that loaded them
      if (fall) begin
         if (mode == cbl_pkg::cbl_mode_serial) begin
            if (ser_pend) begin
               bit_ev = 1'b1;
               bit_val = ser_bit;
               next_ser_pend = 1'b0;
            end
         end else if (sh_left != 4'h0) begin
            bit_ev = 1'b1;                                        // [RULE12]
            bit_val = shreg[7];
            next_shreg = {shreg[6:0], 1'b0};
            next_sh_left = sh_left - 4'h1;
         end
      end
      // Own bits to the byte assembler, the rest down the chain
      if (bit_ev) begin
         if (is_own(bit_cnt)) begin
            next_asm_byte = {asm_byte[6:0], bit_val};
            next_asm_cnt = asm_cnt + 3'h1;
            if (asm_cnt == 3'h7) begin
               next_push = 1'b1;
               next_push_data = {asm_byte[6:0], bit_val};
            end
            if (bit_cnt == CNT_W'(TOTAL - 1)) begin
               next_done = 1'b1;
            end
         end else begin
            next_chain_dout = bit_val;                            // Changes on fall only [RULE2] [RULE3]
         end
         if (bit_cnt != '1) begin
            next_bit_cnt = bit_cnt + 1'b1;
         end
      end
      // Clock out follows the phase once the first byte is in
      next_config_clock_out = next_m_started && next_ph;
   end

   // Loader registers
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state <= cbl_pkg::cbl_st_clear;
         mode <= cbl_pkg::cbl_mode_none;
         clr_cnt <= '0;
         init_out <= 1'b0;
         init_oe <= 1'b1;
         div <= '0;
         ph <= 1'b0;
         m_started <= 1'b0;
         m_strobe <= 1'b0;
         bytes_read <= '0;
         rom_addr <= '0;
         rom_read_strobe <= 1'b0;
         byte_ph <= 3'(`CBL_BYTE_EDGES - `CBL_SYNC_FIRST_EDGE);
         asm_cnt <= '0;
         shreg <= '0;
         asm_byte <= '0;
         push_data <= '0;
         sh_left <= '0;
         ser_bit <= 1'b0;
         ser_pend <= 1'b0;
         push <= 1'b0;
         bit_cnt <= '0;
         config_clock_out <= 1'b0;
         config_clock_oe <= 1'b0;
         chain_dout <= 1'b1;
         byte_ack <= 1'b0;
         mode_pullup_en <= 1'b1;
         config_done <= 1'b0;
         overflow_err <= 1'b0;
      end else begin
         state <= next_state;
         mode <= next_mode;
         clr_cnt <= next_clr_cnt;
         init_out <= 1'b0;                                        // Only ever pulls low [RULE7]
         init_oe <= next_init_oe;
         div <= next_div;
         ph <= next_ph;
         m_started <= next_m_started;
         m_strobe <= next_m_strobe;
         bytes_read <= next_bytes_read;
         rom_addr <= next_rom_addr;
         rom_read_strobe <= next_m_strobe;
         byte_ph <= next_byte_ph;
         asm_cnt <= next_asm_cnt;
         shreg <= next_shreg;
         asm_byte <= next_asm_byte;
         push_data <= next_push_data;
         sh_left <= next_sh_left;
         ser_bit <= next_ser_bit;
         ser_pend <= next_ser_pend;
         push <= next_push;
         bit_cnt <= next_bit_cnt;
         config_clock_out <= next_config_clock_out;
         config_clock_oe <= next_config_clock_oe;
         chain_dout <= next_chain_dout;
         byte_ack <= next_byte_ack;
         mode_pullup_en <= !next_done;                            // Pins read high if left open [RULE5]
         config_done <= next_done;
         overflow_err <= next_ovf;
      end
   end

   // Own bytes wait here for the config memory writer
   cbl_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .in_valid(push),
      .in_data(push_data),
      .in_ready(fifo_in_ready),
      .out_valid(cfg_valid),
      .out_data(cfg_byte),
      .out_ready(cfg_ready)
   );

   // Helper: peripheral rises since the last capture
   logic [3:0] a_since;
   logic a_first;
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         a_since <= '0;
         a_first <= 1'b0;
      end else if (sync_cap) begin
         a_since <= '0;
         a_first <= 1'b1;
      end else if (rise && mode == cbl_pkg::cbl_mode_sync && a_since != 4'hf) begin
         a_since <= a_since + 4'h1;
      end
   end

   serial_sample_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE1]
      rise && mode == cbl_pkg::cbl_mode_serial |=> ser_bit == $past(din_lvl) && ser_pend)
      else $error("serial bit not taken on rise");
   chain_forward_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE2]
      bit_ev && !is_own(bit_cnt) |=> chain_dout == $past(bit_val))
      else $error("forwarded bit missing on chain output");
   dout_on_fall_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE3]
      $changed(chain_dout) |-> $past(fall))
      else $error("chain output moved off a falling edge");
   mode_decode_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE4]
      state == cbl_pkg::cbl_st_clear && next_state == cbl_pkg::cbl_st_wait && pins == `CBL_PINS_SERIAL
      |=> mode == cbl_pkg::cbl_mode_serial) else $error("all-ones pins not slave serial");
   init_open_drain_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE7]
      init_oe |-> !init_out) else $error("status line driven high");
   master_load_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE8]
      m_load |=> sh_left == `CBL_BYTE_BITS && config_clock_out && !rom_read_strobe)
      else $error("master byte not loaded at strobe end");
   sync_first_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE9]
      sync_cap && !a_first |-> a_since == 4'(`CBL_SYNC_FIRST_EDGE - 1))
      else $error("first peripheral byte not on second rise");
   sync_period_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE10]
      sync_cap && a_first |-> a_since == 4'(`CBL_BYTE_EDGES - 1))
      else $error("peripheral byte not on eighth rise");
   ack_pulse_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE11]
      $rose(byte_ack) |-> $past(sync_cap) ##1 (byte_ack throughout (!rise [*1])))
      else $error("acknowledge not tied to capture");
   shift_start_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE12]
      sync_cap |=> sh_left == `CBL_BYTE_BITS && shreg == $past(pbyte))
      else $error("peripheral byte not loaded for shifting");
   addr_step_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE13]
      m_load && mode == cbl_pkg::cbl_mode_mpar_up |=> rom_addr == $past(rom_addr) + 1'b1)
      else $error("ROM address did not step up");
   mode_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE14]
      state != cbl_pkg::cbl_st_clear |=> $stable(mode)) else $error("mode changed after sampling");
endmodule
`default_nettype wire

// *** sim/cbl_rom_model.sv ***
// Purpose: Byte-wide ROM at the loader's far side, master parallel modes
// Assumes: Content is a fixed pattern of the address
// Notes: Outside a read the ROM shows the inverse byte, so a stale byte never passes
`timescale 1ns/1ns
`default_nettype none
module cbl_rom_model (
   // ROM pins
   input wire logic [17:0] addr,
   input wire logic rd,
   output logic [7:0] data
);
   // Valid only while the read strobe is high, which the loader holds until the rise that loads the byte
   assign data = rd ? (addr[7:0] ^ 8'h5a) : ~(addr[7:0] ^ 8'h5a);
endmodule
`default_nettype wire

// *** sim/tb_cbl_loader.sv ***
// Purpose: Self-checking bench for the loader in serial, peripheral and master up modes
// Assumes: Preamble of 8 bits and 16 own bits keep every run short
// Notes: Expected bytes are queued by the driver and popped by the output watcher
`timescale 1ns/1ns
`default_nettype none
module tb_cbl_loader;
   localparam int PRE = 8;
   localparam int CFG = 16;
   logic sys_clk = 0, rst_n = 0, config_clock = 0, din = 0, mst = 0, cfg_ready = 0, dout_s, ack_s;
   logic [2:0] mode = 3'h7;
   logic [7:0] host_byte = 8'h00, rom_data, cfg_byte;
   logic [31:0] s;
   logic [17:0] addr;
   logic init_out, init_oe, cko, ckoe, chain_dout, rd, byte_ack, pu, cfg_valid, done, ovf;
   logic [7:0] exp_q[$];
   int error_cnt = 0, check_count = 0;
   cbl_loader #(.PREAMBLE_BITS(PRE), .CONFIG_BITS(CFG)) u_cbl_loader (.sys_clk(sys_clk), .rst_n(rst_n),
      .mode_select_hi(mode[2]), .mode_select_mid(mode[1]), .mode_select_lo(mode[0]),
      .init_in(!init_oe), .init_out(init_out), .init_oe(init_oe),
      .config_clock_in(ckoe ? cko : config_clock), .config_clock_out(cko), .config_clock_oe(ckoe),
      .serial_din(din), .parallel_config_byte(mst ? rom_data : host_byte), .chain_dout(chain_dout),
      .rom_read_strobe(rd), .rom_addr(addr), .byte_ack(byte_ack), .mode_pullup_en(pu),
      .cfg_valid(cfg_valid), .cfg_byte(cfg_byte), .cfg_ready(cfg_ready), .config_done(done),
      .overflow_err(ovf));
   cbl_rom_model u_cbl_rom_model (.addr(addr), .rd(rd), .data(rom_data));
   // Clock at 125 MHz
   always #4 sys_clk = ~sys_clk;
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Reset, select the mode, let memory clear finish; the status line is pulled up
   task automatic start(input logic [2:0] m);
      @(negedge sys_clk);
      rst_n = 0;
      mode = m;
      mst = (m == 3'h4);
      repeat (6) @(negedge sys_clk);
      rst_n = 1;
      chk({7'h0, init_oe}, 8'h01);
      repeat (700) @(negedge sys_clk);
      chk({6'h0, init_oe, pu}, 8'h01);
   endtask
   // One config clock period of 80 ns, outputs sampled just before the fall
   // Both halves are counted in falling sys_clk edges, so the link clock keeps
   // its period and never races the bench clock
   task automatic pulse(input logic b);
      din = b;
      config_clock = 1;
      repeat (5) @(negedge sys_clk);
      dout_s = chain_dout;
      ack_s = byte_ack;
      config_clock = 0;
      repeat (5) @(negedge sys_clk);
   endtask
   // Watcher: every own byte handed out must be the oldest expected one
   always @(posedge sys_clk) begin
      if (rst_n && cfg_valid && cfg_ready) chk(cfg_byte, exp_q.size() ? exp_q.pop_front() : ~cfg_byte);
   end
   // Random back-pressure on the own byte output
   always @(negedge sys_clk) cfg_ready <= 1'($urandom % 2);
   initial begin
      void'($urandom(32'hbd4178aa));
      // Slave serial: preamble and overflow forwarded half a period late, own bits kept
      start(3'h7);
      s = $urandom;
      exp_q.push_back(s[23:16]);
      exp_q.push_back(s[15:8]);
      // While own bits pass, the chain output keeps the last preamble bit
      for (int i = 0; i < 33; i++) begin
         pulse(s[(31 - i) & 31]);
         if (i > 0) chk({7'h0, dout_s}, (i - 1 < PRE || i - 1 >= PRE + CFG) ? {7'h0, s[32 - i]} : {7'h0, s[32 - PRE]});
      end
      chk({7'h0, done}, 8'h01);
      $display("serial test done");
      // Synchronous peripheral: first byte on second rise, then every eighth, ack one period
      start(3'h3);
      s = $urandom;
      exp_q.push_back(s[15:8]);
      exp_q.push_back(s[7:0]);
      // Capture goes on every eighth rise, so the fourth byte wraps to the top of s
      for (int r = 1; r <= 27; r++) begin
         host_byte = s[((23 - 8 * ((r < 2 ? 0 : r - 2) / 8)) & 31) -: 8];
         pulse(1'b1);
         chk({7'h0, ack_s}, {7'h0, (r >= 2 && (r - 2) % 8 == 0)});
         if (r >= 3 && r <= 10) chk({7'h0, dout_s}, {7'h0, s[26 - r]});
      end
      chk({7'h0, ovf}, 8'h00);
      $display("peripheral test done");
      // Master parallel up: ROM read byte by byte, address steps upward
      exp_q.push_back(8'h5b);
      exp_q.push_back(8'h58);
      start(3'h4);
      for (int k = 0; k < 8000 && !done; k++) @(negedge sys_clk);
      repeat (20) @(negedge sys_clk);
      chk({7'h0, done}, 8'h01);
      chk(addr[7:0], 8'h03);
      chk({6'h0, ckoe, init_out}, 8'h02);
      chk(8'(exp_q.size()), 8'h00);
      $display("master test done");
      report_and_stop();
   end
   // Watchdog, well beyond the some 50 us the three tests need
   initial begin
      #200000;
      error_cnt++;
      report_and_stop();
   end
endmodule
`default_nettype wire
